//--- verilog/nsw_pkg.sv
// Package: encodings, field positions and timing for the nibble exchange unit
package nsw_pkg;
   // Instruction word layout
   localparam logic [5:0] NSW_OPCODE       = 6'h0e;
   localparam int         NSW_OPC_LSB      = 10;
   localparam int         NSW_DEST_BIT     = 9;
   localparam int         NSW_ACC_BIT      = 8;
   localparam logic [7:0] NSW_INDEX_LIMIT  = 8'h5f;
   // Quarter phases per instruction cycle
   localparam int         NSW_Q_PER_CYCLE  = 4;
   localparam logic [1:0] NSW_Q_LAST       = 2'h3;
   // Reset values
   localparam logic [7:0] NSW_W_RESET      = 8'h00;
   localparam logic [1:0] NSW_Q_RESET      = 2'h0;
   // Access bank upper half maps into this bank (address bits 11:8)
   localparam logic [3:0] NSW_ACCESS_SFR_BANK = 4'hf;

   typedef enum logic [1:0] {
      NSW_Q1,
      NSW_Q2,
      NSW_Q3,
      NSW_Q4
   } nsw_phase_t;
endpackage

//--- verilog/nsw_quarter.sv
// Quarter phase generator: one instruction cycle per four system clocks
`timescale 1ns/1ps
module nsw_quarter
   import nsw_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       rstn_in,
   output logic [1:0]      q_out,
   output logic            q4_out
);
   logic [1:0] q_q;
   logic [1:0] q_d;

   // Free running modulo four count
   always_comb begin
      q_d = q_q + 2'h1;
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         q_q <= NSW_Q_RESET;
      end else begin
         q_q <= q_d;
      end
   end

   assign q_out  = q_q;
   assign q4_out = (q_q == NSW_Q_LAST);

   // Four system clocks between instruction cycle ends
   q4_spacing_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      q4_out |=> !q4_out [*3] ##1 q4_out)
      else $error("quarter phase spacing is not four");
endmodule

//--- verilog/nsw_core.sv
// Nibble exchange instruction execution datapath
`timescale 1ns/1ps
module nsw_core
   import nsw_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        rstn_in,
   input  wire logic [15:0] instr_in,
   input  wire logic        instr_valid_in,
   input  wire logic        ext_set_en_in,
   input  wire logic [3:0]  bank_select_register_in,
   input  wire logic [11:0] fsr2_base_in,
   input  wire logic [7:0]  mem_rdata_in,
   output logic [11:0]      mem_addr_out,
   output logic             mem_rd_out,
   output logic             mem_wr_out,
   output logic [7:0]       mem_wdata_out,
   output logic [7:0]       w_reg_out,
   output logic             w_wr_out,
   output logic             illegal_out,
   output logic             done_out,
   output logic             flags_wr_out
);
   logic [1:0]  q;
   logic        q4;
   logic [15:0] ir_q,    ir_d;
   logic        busy_q,  busy_d;
   logic [11:0] addr_q,  addr_d;
   logic        rd_q,    rd_d;
   logic [7:0]  res_q,   res_d;
   logic        wr_q,    wr_d;
   logic [7:0]  wreg_q,  wreg_d;
   logic        wwr_q,   wwr_d;
   logic        ill_q,   ill_d;
   logic        done_q,  done_d;
   logic        hit;
   logic        dest;
   logic        acc;
   logic [7:0]  fa;
   logic        indexed;

   nsw_quarter u_quarter (
      .sys_clk_in (sys_clk_in),
      .rstn_in    (rstn_in),
      .q_out      (q),
      .q4_out     (q4)
   );

   // Field decode of the held instruction word
   assign hit  = (ir_q[15:NSW_OPC_LSB] == NSW_OPCODE);
   assign dest = ir_q[NSW_DEST_BIT];
   assign acc  = ir_q[NSW_ACC_BIT];
   assign fa   = ir_q[7:0];
   assign indexed = !acc && ext_set_en_in
                    && (fa <= NSW_INDEX_LIMIT);

   // Phase sequencing: Q1 decode, Q2 read, Q3 swap, Q4 write
   always_comb begin
      ir_d   = ir_q;
      busy_d = busy_q;
      addr_d = addr_q;
      rd_d   = 1'b0;
      res_d  = res_q;
      wr_d   = 1'b0;
      wreg_d = wreg_q;
      wwr_d  = 1'b0;
      ill_d  = 1'b0;
      done_d = 1'b0;
      case (nsw_phase_t'(q))
         NSW_Q1: begin
            // Only accepted at a cycle boundary, keeps cycle alignment
            ir_d   = instr_in;
            busy_d = instr_valid_in;
         end
         NSW_Q2: begin
            if (busy_q && hit) begin
               if (indexed) begin
                  addr_d = fsr2_base_in + {4'h0, fa};
               end else if (acc) begin
                  addr_d = {bank_select_register_in, fa};
               end else if (fa[7]) begin
                  // Upper access half maps to the special bank
                  addr_d = {NSW_ACCESS_SFR_BANK, fa};
               end else begin
                  addr_d = {4'h0, fa};
               end
               rd_d = 1'b1;
            end
         end
         NSW_Q3: begin
            // Read data arrives one clock after the strobe
            res_d = {mem_rdata_in[3:0], mem_rdata_in[7:4]};
         end
         NSW_Q4: begin
            if (busy_q && hit) begin
               if (dest) begin
                  wr_d = 1'b1;
               end else begin
                  wreg_d = res_q;
                  wwr_d  = 1'b1;
               end
               done_d = 1'b1;
            end else if (busy_q) begin
               ill_d = 1'b1;
            end
            busy_d = 1'b0;
         end
         default: begin
            busy_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         ir_q   <= 16'h0000;
         busy_q <= 1'b0;
         addr_q <= 12'h000;
         rd_q   <= 1'b0;
         res_q  <= 8'h00;
         wr_q   <= 1'b0;
         wreg_q <= NSW_W_RESET;
         wwr_q  <= 1'b0;
         ill_q  <= 1'b0;
         done_q <= 1'b0;
      end else begin
         ir_q   <= ir_d;
         busy_q <= busy_d;
         addr_q <= addr_d;
         rd_q   <= rd_d;
         res_q  <= res_d;
         wr_q   <= wr_d;
         wreg_q <= wreg_d;
         wwr_q  <= wwr_d;
         ill_q  <= ill_d;
         done_q <= done_d;
      end
   end

   // Outputs straight from flip-flops
   assign mem_addr_out  = addr_q;
   assign mem_rd_out    = rd_q;
   assign mem_wr_out    = wr_q;
   assign mem_wdata_out = res_q;
   assign w_reg_out     = wreg_q;
   assign w_wr_out      = wwr_q;
   assign illegal_out   = ill_q;
   assign done_out      = done_q;
   // Status flags are never touched by this operation
   assign flags_wr_out  = 1'b0;

   // Read byte split in halves so the checks can look back at each one
   logic [3:0]  rdata_lo;
   logic [3:0]  rdata_hi;
   assign rdata_lo = mem_rdata_in[3:0];
   assign rdata_hi = mem_rdata_in[7:4];

   // Swapped result matches the byte present at the Q3 edge
   swap_result_a: assert property (@(posedge sys_clk_in)
      disable iff (!rstn_in)
      rd_q |=> res_q == {$past(rdata_lo), $past(rdata_hi)})
      else $error("nibble swap result wrong");

   // Memory write only for destination one, together with done
   mem_write_dest_a: assert property (@(posedge sys_clk_in)
      disable iff (!rstn_in)
      mem_wr_out |-> $past(dest) && done_q)
      else $error("memory write without destination one");

   // Working register write carries the same swapped byte
   w_write_dest_a: assert property (@(posedge sys_clk_in)
      disable iff (!rstn_in)
      w_wr_out |-> !$past(dest) && done_q && w_reg_out == mem_wdata_out)
      else $error("working register write wrong");

   // A write never goes to both destinations at once
   dest_exclusive_a: assert property (@(posedge sys_clk_in)
      disable iff (!rstn_in)
      !(mem_wr_out && w_wr_out))
      else $error("both destinations written");

   // Working register only moves on its own write pulse
   w_hold_a: assert property (@(posedge sys_clk_in)
      disable iff (!rstn_in)
      !w_wr_out |-> $stable(w_reg_out))
      else $error("working register changed without write");

   // Banked operand address built from bank select and file address
   banked_addr_a: assert property (@(posedge sys_clk_in)
      disable iff (!rstn_in)
      rd_d && acc |=> mem_addr_out == {$past(bank_select_register_in),
                                       $past(fa)})
      else $error("banked address wrong");

   // Indexed offset wraps at twelve bits, same as the data space
   indexed_addr_a: assert property (@(posedge sys_clk_in)
      disable iff (!rstn_in)
      rd_d && indexed |=> mem_addr_out ==
         $past(fsr2_base_in) + {4'h0, $past(fa)})
      else $error("indexed address wrong");

   // Status flags are never written by this operation
   flags_hold_a: assert property (@(posedge sys_clk_in)
      disable iff (!rstn_in)
      !flags_wr_out)
      else $error("status flags written");

   // Read strobe to completion within the same instruction cycle
   one_cycle_a: assert property (@(posedge sys_clk_in)
      disable iff (!rstn_in)
      mem_rd_out |-> ##2 (done_out || illegal_out))
      else $error("instruction not done in one cycle");

   // Refused word leaves memory, working register and done alone
   illegal_quiet_a: assert property (@(posedge sys_clk_in)
      disable iff (!rstn_in)
      illegal_out |-> !mem_wr_out && !w_wr_out && !done_out)
      else $error("refused word produced a write");

   // At most one completion per four system clocks
   done_spacing_a: assert property (@(posedge sys_clk_in)
      disable iff (!rstn_in)
      done_out |=> !done_out [*3])
      else $error("done faster than one per four clocks");

   // Completion only follows the last quarter of a cycle
   done_phase_a: assert property (@(posedge sys_clk_in)
      disable iff (!rstn_in)
      done_out |-> $past(q4))
      else $error("done outside the last quarter");

   mem_wb_c: cover property (@(posedge sys_clk_in) mem_wr_out);
   w_wb_c:   cover property (@(posedge sys_clk_in) w_wr_out);
   idx_c:    cover property (@(posedge sys_clk_in) rd_d && indexed);
   ill_c:    cover property (@(posedge sys_clk_in) illegal_out);
endmodule

//--- tb/test_nsw_core.sv
// Self-checking bench for the nibble exchange datapath
`timescale 1ns/1ps
module test_nsw_core;
   import nsw_pkg::*;
   logic        sys_clk_in;
   logic        rstn_in;
   logic [15:0] instr_in;
   logic        instr_valid_in;
   logic        ext_set_en_in;
   logic [3:0]  bank_select_register_in;
   logic [11:0] fsr2_base_in;
   logic [7:0]  mem_rdata_in;
   logic [11:0] mem_addr_out;
   logic        mem_rd_out, mem_wr_out, w_wr_out;
   logic        illegal_out, done_out, flags_wr_out;
   logic [7:0]  mem_wdata_out, w_reg_out;
   int          failures;
   int          cmp_count;

   nsw_core dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
      .instr_in(instr_in), .instr_valid_in(instr_valid_in),
      .ext_set_en_in(ext_set_en_in),
      .bank_select_register_in(bank_select_register_in),
      .fsr2_base_in(fsr2_base_in), .mem_rdata_in(mem_rdata_in),
      .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
      .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out),
      .w_reg_out(w_reg_out), .w_wr_out(w_wr_out),
      .illegal_out(illegal_out), .done_out(done_out),
      .flags_wr_out(flags_wr_out));

   // 250 MHz system clock
   initial begin
      sys_clk_in = 1'b0;
      forever #2 sys_clk_in = ~sys_clk_in;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Operand address expected for a word and the bank state
   function automatic logic [11:0] exp_addr(logic [15:0] w, logic ext,
                                            logic [3:0] bank_select_register, logic [11:0] b);
      if (w[8]) return {bank_select_register, w[7:0]};
      if (ext && w[7:0] <= 8'h5f) return b + {4'h0, w[7:0]};
      return {(w[7] ? 4'hf : 4'h0), w[7:0]};
   endfunction

   // Nibble exchange of a byte, worked out from the rule
   function automatic logic [7:0] exp_swap(logic [7:0] b);
      return {b[3:0], b[7:4]};
   endfunction

   // One instruction slot of eight clocks, entered at a drive edge
   task automatic op(input logic [15:0] w, input logic ext,
                     input logic [7:0] rd);
      logic [3:0]  bank_select_register;
      logic [11:0] base;
      logic        legal;
      bank_select_register = 4'($urandom);
      base = 12'($urandom);
      legal = (w[15:10] === NSW_OPCODE);
      instr_in <= w;
      instr_valid_in <= 1'b1;
      ext_set_en_in <= ext;
      bank_select_register_in <= bank_select_register;
      fsr2_base_in <= base;
      mem_rdata_in <= rd;
      @(posedge sys_clk_in);
      // Off-phase swap word, held valid over two edges, must be ignored
      instr_in <= {NSW_OPCODE, 10'($urandom)};
      @(posedge sys_clk_in);
      #1;
      chk(16'(mem_rd_out), 16'(legal));
      if (legal) begin
         chk(16'(mem_addr_out), 16'(exp_addr(w, ext, bank_select_register, base)));
      end
      @(posedge sys_clk_in);
      instr_valid_in <= 1'b0;
      @(posedge sys_clk_in);
      #1;
      chk({done_out, illegal_out, flags_wr_out},
          {legal, !legal, 1'b0});
      if (legal) begin
         chk({mem_wr_out, w_wr_out}, {w[9], !w[9]});
         chk(w[9] ? mem_wdata_out : w_reg_out, exp_swap(rd));
      end
      repeat (3) begin
         @(posedge sys_clk_in);
         #1;
         chk({done_out, illegal_out}, 16'h0);
      end
      @(posedge sys_clk_in);
   endtask

   // Watchdog well beyond the expected run of about 400 clocks
   initial begin
      #20000;
      failures++;
      complete_run;
   end

   initial begin
      failures = 0;
      cmp_count = 0;
      rstn_in = 1'b0;
      instr_in = 16'h0000;
      instr_valid_in = 1'b0;
      ext_set_en_in = 1'b0;
      bank_select_register_in = 4'h0;
      fsr2_base_in = 12'h000;
      mem_rdata_in = 8'h00;
      void'($urandom(32'h2d83));
      repeat (9) @(posedge sys_clk_in);
      #1;
      chk({mem_rd_out, mem_wr_out, w_wr_out, done_out, w_reg_out},
          16'h0);
      @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      // Index limit edges, access bank halves, bank select, bad opcode
      op({NSW_OPCODE, 2'b10, 8'h5f}, 1'b1, 8'h53);
      op({NSW_OPCODE, 2'b00, 8'h60}, 1'b1, 8'ha5);
      op({NSW_OPCODE, 2'b00, 8'h80}, 1'b0, 8'h0f);
      op({NSW_OPCODE, 2'b11, 8'h7f}, 1'b1, 8'hf0);
      op({6'h0f, 10'h3ff}, 1'b1, 8'h12);
      for (int i = 0; i < 40; i++) begin
         op({(i % 5 == 0) ? 6'($urandom) : NSW_OPCODE, 10'($urandom)},
            1'($urandom), 8'($urandom));
      end
      // Swap word with valid low at the take edge is refused quietly
      instr_in <= {NSW_OPCODE, 10'h3ff};
      instr_valid_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      #1;
      chk(16'(mem_rd_out), 16'h0);
      repeat (2) @(posedge sys_clk_in);
      #1;
      chk({done_out, illegal_out, mem_wr_out, w_wr_out}, 16'h0);
      complete_run;
   end
endmodule
